// *** design/riw_defines.svh ***
// Register indices, reset values, masks and vectors of the init block.
`ifndef RIW_DEFINES_SVH
`define RIW_DEFINES_SVH

// Number of word registers; byte address is four times the index.
`define RIW_NUM_REGS 36
`define RIW_IX_IND_PTR1_HIGH 6'd0
`define RIW_IX_IND_PTR1_LOW 6'd1
`define RIW_IX_MEM_BANK_SELECT 6'd2
`define RIW_IX_IND_PTR2_HIGH 6'd3
`define RIW_IX_IND_PTR2_LOW 6'd4
`define RIW_IX_ARITH_FLAGS 6'd5
`define RIW_IX_TMR_ZERO_HIGH 6'd6
`define RIW_IX_TMR_ZERO_LOW 6'd7
`define RIW_IX_TMR_ZERO_CTRL 6'd8
`define RIW_IX_OSC_CTRL 6'd9
`define RIW_IX_VDET_CTRL 6'd10
`define RIW_IX_WDOG_CTRL 6'd11
`define RIW_IX_RST_CAUSE 6'd12
`define RIW_IX_TMR_ONE_HIGH 6'd13
`define RIW_IX_TMR_ONE_LOW 6'd14
`define RIW_IX_TMR_ONE_CTRL 6'd15
`define RIW_IX_TMR_TWO_COUNT 6'd16
`define RIW_IX_TMR_TWO_PERIOD 6'd17
`define RIW_IX_TMR_TWO_CTRL 6'd18
`define RIW_IX_SSER_BUFFER 6'd19
`define RIW_IX_SSER_ADDR_BAUD 6'd20
`define RIW_IX_SSER_STATUS 6'd21
`define RIW_IX_SSER_CTRL_A 6'd22
`define RIW_IX_SSER_CTRL_B 6'd23
`define RIW_IX_STACK_TOP_UPPER 6'd24
`define RIW_IX_STACK_TOP_HIGH 6'd25
`define RIW_IX_STACK_TOP_LOW 6'd26
`define RIW_IX_STACK_INDEX 6'd27
`define RIW_IX_PORT_A_PINS 6'd28
`define RIW_IX_PORT_A_LATCH 6'd29
`define RIW_IX_PORT_A_DIR 6'd30
`define RIW_IX_IRQ_CONTROL 6'd31
`define RIW_IX_PERIPH_FLAGS 6'd32
`define RIW_IX_EVT_STATUS 6'd33
`define RIW_IX_EVT_MASK 6'd34
`define RIW_IX_PC_SHADOW 6'd35

// Power-on values that are not zero.
`define RIW_POR_TMR_ZERO_CTRL 8'hFF
`define RIW_POR_OSC_CTRL 8'h40
`define RIW_POR_VDET_CTRL 8'h05
`define RIW_POR_RST_CAUSE 8'h1C
`define RIW_POR_TMR_TWO_PERIOD 8'hFF
`define RIW_POR_PORT_A_DIR 8'hFF
// Bits kept by warm resets.
`define RIW_KEEP_ALL 8'hFF
`define RIW_KEEP_NONE 8'h00
`define RIW_KEEP_ARITH 8'h1F
`define RIW_KEEP_RST_CAUSE 8'h03
`define RIW_KEEP_TMR_ONE_CTRL 8'hBF
`define RIW_KEEP_STACK_INDEX 8'hC0
`define RIW_KEEP_IRQ_CONTROL 8'h01
// Implemented bits.
`define RIW_IMPL_NIBBLE 8'h0F
`define RIW_IMPL_FIVE 8'h1F
`define RIW_IMPL_VDET 8'hBF
`define RIW_IMPL_ONE 8'h01
`define RIW_IMPL_RST_CAUSE 8'hDF
`define RIW_IMPL_TMR_TWO_CTRL 8'h7F
`define RIW_IMPL_STACK_INDEX 8'hDF
`define RIW_PORT_GATE_MASK 8'h3F
// Field positions and vectors.
`define RIW_BIT_HIGH_GIE 7
`define RIW_BIT_LOW_GIE 6
`define RIW_HIGH_VECTOR 21'h000008
`define RIW_LOW_VECTOR 21'h000018
`define RIW_EVT_POR 0
`define RIW_EVT_WARM 1
`define RIW_EVT_WAKE_WDT 2
`define RIW_EVT_WAKE_IRQ 3
`define RIW_EVT_VECTOR 4

`endif

// *** design/riw_pkg.sv ***
// Types shared by the reset and wake initialisation block.
package riw_pkg;
    // Register index type.
    typedef logic [5:0] riw_idx_t;
    // Reset class applied in a cycle.
    typedef enum logic [1:0] {
        RIW_CLS_NONE = 2'b00,
        RIW_CLS_POR = 2'b01,
        RIW_CLS_WARM = 2'b10,
        RIW_CLS_WAKE = 2'b11
    } riw_cls_t;
endpackage

// *** design/riw_top.sv ***
// Special-function register bank with reset-class and wake-up init.
`timescale 1ns/1ps
`include "riw_defines.svh"
module riw_top (
    // APB clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave port.
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Reset and wake sources, one-cycle pulses.
    input wire logic por_bor_req,
    input wire logic warm_rst_req,
    input wire logic wake_wdt_req,
    input wire logic wake_irq_req,
    input wire logic wake_irq_high,
    input wire logic [7:0] wake_flags,
    // Core state and pins.
    input wire logic [20:0] pc_in,
    input wire logic osc_frees_pins,
    input wire logic [7:0] port_a_in,
    // Program counter load.
    output logic pc_load,
    output logic [20:0] pc_vector,
    // Port A drive.
    output logic [7:0] port_a_out,
    output logic [7:0] port_a_oe,
    // Interrupt.
    output logic irq_out
);
    import riw_pkg::*;

    // Register storage, one byte per word.
    logic [7:0] sfr_reg [0:`RIW_NUM_REGS-1];
    // Registered bus outputs.
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    // Registered side outputs.
    logic pc_load_reg;
    logic [20:0] pc_vector_reg;
    logic [7:0] port_a_out_reg;
    logic [7:0] port_a_oe_reg;
    logic irq_out_reg;
    // Decoded request and class.
    riw_idx_t bus_ix;
    logic addr_ok;
    logic xfer_done;
    logic wr_commit;
    logic rd_status;
    logic vec_take;
    logic [7:0] events;
    riw_cls_t rst_class;

    // Power-on value of a register.
    function automatic logic [7:0] por_value(input riw_idx_t ix);
        case (ix)
            `RIW_IX_TMR_ZERO_CTRL: por_value = `RIW_POR_TMR_ZERO_CTRL;
            `RIW_IX_OSC_CTRL: por_value = `RIW_POR_OSC_CTRL;
            `RIW_IX_VDET_CTRL: por_value = `RIW_POR_VDET_CTRL;
            `RIW_IX_RST_CAUSE: por_value = `RIW_POR_RST_CAUSE;
            `RIW_IX_TMR_TWO_PERIOD: por_value = `RIW_POR_TMR_TWO_PERIOD;
            `RIW_IX_PORT_A_DIR: por_value = `RIW_POR_PORT_A_DIR;
            default: por_value = 8'h00;
        endcase
    endfunction

    // Bits that a warm reset leaves unchanged.
    function automatic logic [7:0] keep_mask(input riw_idx_t ix);
        case (ix)
            `RIW_IX_IND_PTR1_LOW, `RIW_IX_IND_PTR2_LOW,
            `RIW_IX_TMR_ZERO_LOW, `RIW_IX_TMR_ONE_HIGH,
            `RIW_IX_TMR_ONE_LOW, `RIW_IX_SSER_BUFFER,
            `RIW_IX_PORT_A_LATCH, `RIW_IX_EVT_STATUS,
            `RIW_IX_EVT_MASK: keep_mask = `RIW_KEEP_ALL;
            `RIW_IX_ARITH_FLAGS: keep_mask = `RIW_KEEP_ARITH;
            `RIW_IX_RST_CAUSE: keep_mask = `RIW_KEEP_RST_CAUSE;
            `RIW_IX_TMR_ONE_CTRL: keep_mask = `RIW_KEEP_TMR_ONE_CTRL;
            `RIW_IX_STACK_INDEX: keep_mask = `RIW_KEEP_STACK_INDEX;
            `RIW_IX_IRQ_CONTROL: keep_mask = `RIW_KEEP_IRQ_CONTROL;
            default: keep_mask = `RIW_KEEP_NONE;
        endcase
    endfunction

    // Implemented bits; the rest are held and read as zero.
    function automatic logic [7:0] impl_mask(input riw_idx_t ix);
        case (ix)
            `RIW_IX_IND_PTR1_HIGH, `RIW_IX_MEM_BANK_SELECT,
            `RIW_IX_IND_PTR2_HIGH: impl_mask = `RIW_IMPL_NIBBLE;
            `RIW_IX_ARITH_FLAGS, `RIW_IX_STACK_TOP_UPPER,
            `RIW_IX_EVT_STATUS, `RIW_IX_EVT_MASK,
            `RIW_IX_PC_SHADOW: impl_mask = `RIW_IMPL_FIVE;
            `RIW_IX_VDET_CTRL: impl_mask = `RIW_IMPL_VDET;
            `RIW_IX_WDOG_CTRL: impl_mask = `RIW_IMPL_ONE;
            `RIW_IX_RST_CAUSE: impl_mask = `RIW_IMPL_RST_CAUSE;
            `RIW_IX_TMR_TWO_CTRL: impl_mask = `RIW_IMPL_TMR_TWO_CTRL;
            `RIW_IX_STACK_INDEX: impl_mask = `RIW_IMPL_STACK_INDEX;
            default: impl_mask = 8'hFF;
        endcase
    endfunction

    // Port A registers lose bits 6 and 7 unless the oscillator frees them.
    function automatic logic [7:0] port_gate(input riw_idx_t ix,
                                             input logic freed);
        if ((ix == `RIW_IX_PORT_A_PINS || ix == `RIW_IX_PORT_A_LATCH ||
             ix == `RIW_IX_PORT_A_DIR) && !freed)
            port_gate = `RIW_PORT_GATE_MASK;
        else
            port_gate = 8'hFF;
    endfunction

    // Bus decode: word aligned, inside the map.
    assign bus_ix = riw_idx_t'(paddr[7:2]);
    assign addr_ok = (paddr[1:0] == 2'b00) &&
                     (paddr[7:2] < 6'(`RIW_NUM_REGS));
    assign xfer_done = psel && penable && pready_reg;
    assign wr_commit = xfer_done && pwrite && addr_ok;
    assign rd_status = xfer_done && !pwrite && addr_ok &&
                       (bus_ix == `RIW_IX_EVT_STATUS);

    // Reset class priority: power-on, then warm, then wake.
    always_comb
    begin
        if (por_bor_req)
            rst_class = RIW_CLS_POR;
        else if (warm_rst_req)
            rst_class = RIW_CLS_WARM;
        else if (wake_wdt_req || wake_irq_req)
            rst_class = RIW_CLS_WAKE;
        else
            rst_class = RIW_CLS_NONE;
    end

    // Vector is taken only on an interrupt wake with a global enable set.
    assign vec_take = (rst_class == RIW_CLS_WAKE) && wake_irq_req &&
        (sfr_reg[`RIW_IX_IRQ_CONTROL][`RIW_BIT_HIGH_GIE] ||
         sfr_reg[`RIW_IX_IRQ_CONTROL][`RIW_BIT_LOW_GIE]);

    // Events that set sticky status bits.
    always_comb
    begin
        events = 8'h00;
        events[`RIW_EVT_POR] = rst_class == RIW_CLS_POR;
        events[`RIW_EVT_WARM] = rst_class == RIW_CLS_WARM;
        events[`RIW_EVT_WAKE_WDT] = rst_class == RIW_CLS_WAKE &&
                                    wake_wdt_req;
        events[`RIW_EVT_WAKE_IRQ] = rst_class == RIW_CLS_WAKE &&
                                    wake_irq_req;
        events[`RIW_EVT_VECTOR] = vec_take;
    end

    // Register bank: reset classes, bus writes, then hardware updates.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < `RIW_NUM_REGS; i++)
                sfr_reg[i] <= por_value(riw_idx_t'(i)) &
                              impl_mask(riw_idx_t'(i));
        end
        else
        begin
            for (int i = 0; i < `RIW_NUM_REGS; i++)
            begin
                case (rst_class)
                    // Power-on or brown-out loads the first column.
                    RIW_CLS_POR:
                        sfr_reg[i] <= por_value(riw_idx_t'(i)) &
                                      impl_mask(riw_idx_t'(i));
                    // Warm resets keep only the marked bits.
                    RIW_CLS_WARM:
                        sfr_reg[i] <= ((sfr_reg[i] &
                            keep_mask(riw_idx_t'(i))) |
                            (por_value(riw_idx_t'(i)) &
                            ~keep_mask(riw_idx_t'(i)))) &
                            impl_mask(riw_idx_t'(i));
                    // Wake-up keeps each value except for the updates below; idle cycles take writes.
                    RIW_CLS_WAKE:
                        sfr_reg[i] <= sfr_reg[i];
                    RIW_CLS_NONE:
                        if (wr_commit && bus_ix == riw_idx_t'(i) &&
                            bus_ix != `RIW_IX_PORT_A_PINS &&
                            bus_ix != `RIW_IX_EVT_STATUS &&
                            bus_ix != `RIW_IX_PC_SHADOW)
                            sfr_reg[i] <= pwdata[7:0] &
                                          impl_mask(riw_idx_t'(i));
                    default:
                        sfr_reg[i] <= sfr_reg[i];
                endcase
            end
            // Pins are sampled every cycle and gated by the oscillator.
            sfr_reg[`RIW_IX_PORT_A_PINS] <= port_a_in &
                port_gate(`RIW_IX_PORT_A_PINS, osc_frees_pins);
            // Period register reads all ones after a wake-up.
            if (rst_class == RIW_CLS_WAKE)
                sfr_reg[`RIW_IX_TMR_TWO_PERIOD] <= `RIW_POR_TMR_TWO_PERIOD;
            // Wake cause shows in the peripheral flag bits.
            if (rst_class == RIW_CLS_WAKE)
                sfr_reg[`RIW_IX_PERIPH_FLAGS] <=
                    sfr_reg[`RIW_IX_PERIPH_FLAGS] | wake_flags;
            // Vector take pushes the program counter.
            if (vec_take)
            begin
                sfr_reg[`RIW_IX_STACK_TOP_UPPER] <= {3'b000, pc_in[20:16]};
                sfr_reg[`RIW_IX_STACK_TOP_HIGH] <= pc_in[15:8];
                sfr_reg[`RIW_IX_STACK_TOP_LOW] <= pc_in[7:0];
                sfr_reg[`RIW_IX_STACK_INDEX] <=
                    {sfr_reg[`RIW_IX_STACK_INDEX][7:5],
                     5'(sfr_reg[`RIW_IX_STACK_INDEX][4:0] + 5'h01)};
            end
            // Shadow of the core program counter, low five bits.
            sfr_reg[`RIW_IX_PC_SHADOW] <= {3'b000, pc_in[4:0]};
            // Sticky status: a read clears, a new event wins.
            sfr_reg[`RIW_IX_EVT_STATUS] <= ((rd_status ? 8'h00 :
                sfr_reg[`RIW_IX_EVT_STATUS]) | events) &
                impl_mask(`RIW_IX_EVT_STATUS);
        end
    end

    // APB: one wait state, read data and error latched with pready.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end
        else
        begin
            pready_reg <= psel && penable && !pready_reg;
            if (psel && penable && !pready_reg)
            begin
                pslverr_reg <= !addr_ok;
                if (addr_ok && !pwrite)
                    prdata_reg <= {24'h00_0000, sfr_reg[bus_ix] &
                        impl_mask(bus_ix) &
                        port_gate(bus_ix, osc_frees_pins)};
                else
                    prdata_reg <= 32'h0000_0000;
            end
        end
    end

    // Program counter load pulse and vector.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pc_load_reg <= 1'b0;
            pc_vector_reg <= 21'h000000;
        end
        else
        begin
            pc_load_reg <= vec_take;
            if (vec_take)
                pc_vector_reg <= wake_irq_high ? `RIW_HIGH_VECTOR :
                                 `RIW_LOW_VECTOR;
        end
    end

    // Port A drive follows latch and direction, bits 6 and 7 gated.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            port_a_out_reg <= 8'h00;
            port_a_oe_reg <= 8'h00;
        end
        else
        begin
            port_a_out_reg <= sfr_reg[`RIW_IX_PORT_A_LATCH] &
                port_gate(`RIW_IX_PORT_A_LATCH, osc_frees_pins);
            port_a_oe_reg <= ~sfr_reg[`RIW_IX_PORT_A_DIR] &
                port_gate(`RIW_IX_PORT_A_DIR, osc_frees_pins);
        end
    end

    // Interrupt level from unmasked sticky bits.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_out_reg <= 1'b0;
        else
            irq_out_reg <= |(sfr_reg[`RIW_IX_EVT_STATUS] &
                             sfr_reg[`RIW_IX_EVT_MASK]);
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign pc_load = pc_load_reg;
    assign pc_vector = pc_vector_reg;
    assign port_a_out = port_a_out_reg;
    assign port_a_oe = port_a_oe_reg;
    assign irq_out = irq_out_reg;

    // Checks on the block's own behaviour.
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_vector_load: assert property (vec_take |=> pc_load &&
        pc_vector == ($past(wake_irq_high) ? `RIW_HIGH_VECTOR :
        `RIW_LOW_VECTOR)) else $error("vector not loaded");
    a_vector_gated: assert property (wake_irq_req &&
        rst_class == RIW_CLS_WAKE && !sfr_reg[`RIW_IX_IRQ_CONTROL][7] &&
        !sfr_reg[`RIW_IX_IRQ_CONTROL][6] |=> !pc_load)
        else $error("vector taken without enable");
    a_stack_top: assert property (vec_take |=>
        {sfr_reg[`RIW_IX_STACK_TOP_UPPER][4:0],
         sfr_reg[`RIW_IX_STACK_TOP_HIGH],
         sfr_reg[`RIW_IX_STACK_TOP_LOW]} == $past(pc_in))
        else $error("stack top not captured");
    a_stack_advance: assert property (vec_take |=>
        sfr_reg[`RIW_IX_STACK_INDEX][4:0] ==
        5'($past(sfr_reg[`RIW_IX_STACK_INDEX][4:0]) + 5'h01))
        else $error("stack index not advanced");
    a_wake_flags: assert property (rst_class == RIW_CLS_WAKE |=>
        (sfr_reg[`RIW_IX_PERIPH_FLAGS] & $past(wake_flags)) ==
        $past(wake_flags)) else $error("wake flags missing");
    a_port_gate: assert property (!osc_frees_pins [*2] |->
        port_a_oe[7:6] == 2'b00 && port_a_out[7:6] == 2'b00)
        else $error("port bits 6,7 driven");
    a_unimpl_zero: assert property (pready |->
        prdata[31:8] == 24'h00_0000) else $error("upper bits not zero");
    a_por_values: assert property (por_bor_req |=>
        sfr_reg[`RIW_IX_TMR_ZERO_CTRL] == `RIW_POR_TMR_ZERO_CTRL &&
        sfr_reg[`RIW_IX_RST_CAUSE] == `RIW_POR_RST_CAUSE)
        else $error("power-on values wrong");
    a_warm_keep: assert property (rst_class == RIW_CLS_WARM |=>
        sfr_reg[`RIW_IX_TMR_ONE_LOW] == $past(sfr_reg[`RIW_IX_TMR_ONE_LOW])
        && sfr_reg[`RIW_IX_TMR_ZERO_HIGH] == 8'h00)
        else $error("warm reset values wrong");
    a_apb_wait: assert property (psel && penable && !pready |=> pready)
        else $error("apb answer late");

    c_vector_wake: cover property (vec_take ##1 pc_load);
    c_warm_reset: cover property (rst_class == RIW_CLS_WARM);
    c_status_read: cover property (rd_status && irq_out);

    // An event bit lands in status even when a read clears it at once.
    a_event_sticky: assert property ((events != 8'h00) |=>
        (sfr_reg[`RIW_IX_EVT_STATUS] & $past(events)) == $past(events))
        else $error("status event lost");
    // The interrupt level follows the unmasked status bits a cycle later.
    a_irq_level: assert property ((sfr_reg[`RIW_IX_EVT_STATUS] &
        sfr_reg[`RIW_IX_EVT_MASK]) != 8'h00 |=> irq_out)
        else $error("interrupt not raised");
    a_irq_quiet: assert property ((sfr_reg[`RIW_IX_EVT_STATUS] &
        sfr_reg[`RIW_IX_EVT_MASK]) == 8'h00 |=> !irq_out)
        else $error("interrupt raised without cause");
    // Wake-up keeps counters and forces the period register to ones.
    a_wake_keep: assert property (rst_class == RIW_CLS_WAKE |=>
        sfr_reg[`RIW_IX_TMR_ONE_LOW] == $past(sfr_reg[`RIW_IX_TMR_ONE_LOW])
        && sfr_reg[`RIW_IX_TMR_TWO_PERIOD] == `RIW_POR_TMR_TWO_PERIOD)
        else $error("wake values wrong");
    // Sampled pins lose bits 6 and 7 while the oscillator holds them.
    a_pins_gated: assert property (!osc_frees_pins |=>
        sfr_reg[`RIW_IX_PORT_A_PINS][7:6] == 2'b00)
        else $error("pin bits 6,7 sampled");
    // Unused bit 6 of the voltage detect register always reads zero.
    a_unimpl_read: assert property (pready && !pwrite &&
        bus_ix == `RIW_IX_VDET_CTRL |-> prdata[6] == 1'b0)
        else $error("unused bit read as one");

    // Further scenarios worth seeing: a watchdog wake and a power-on class.
    c_wdt_wake: cover property (rst_class == RIW_CLS_WAKE && wake_wdt_req);
    c_por_class: cover property (rst_class == RIW_CLS_POR);
endmodule // riw_top

// *** verif/tb_top.sv ***
// Self-checking bench for the reset and wake init register bank.
`timescale 1ns/1ps
`include "riw_defines.svh"
module tb_top;
    import riw_pkg::*;
    // Bus side of the bench.
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    // Reset and wake sources, core state and pins.
    logic por_bor_req, warm_rst_req, wake_wdt_req, wake_irq_req;
    logic wake_irq_high, osc_frees_pins, pc_load, irq_out;
    logic [7:0] wake_flags, port_a_in, port_a_out, port_a_oe;
    logic [20:0] pc_in, pc_vector;
    // Verdict counters and a cycle count against hangs.
    int err_total = 0;
    int n_tests = 0;
    int cyc = 0;
    // Plain registers: index, implemented bits, bits kept warm, power-on.
    logic [5:0] t_ix [10] = '{6'h00, 6'h01, 6'h02, 6'h05, 6'h06, 6'h0B,
        6'h0F, 6'h11, 6'h17, 6'h1F};
    logic [7:0] t_im [10] = '{8'h0F, 8'hFF, 8'h0F, 8'h1F, 8'hFF, 8'h01,
        8'hFF, 8'hFF, 8'hFF, 8'hFF};
    logic [7:0] t_kp [10] = '{8'h00, 8'hFF, 8'h00, 8'h1F, 8'h00, 8'h00,
        8'hBF, 8'h00, 8'h00, 8'h01};
    logic [7:0] t_po [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'hFF, 8'h00, 8'h00};

    riw_top dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .por_bor_req(por_bor_req), .warm_rst_req(warm_rst_req),
        .wake_wdt_req(wake_wdt_req), .wake_irq_req(wake_irq_req),
        .wake_irq_high(wake_irq_high), .wake_flags(wake_flags),
        .pc_in(pc_in), .osc_frees_pins(osc_frees_pins),
        .port_a_in(port_a_in), .pc_load(pc_load), .pc_vector(pc_vector),
        .port_a_out(port_a_out), .port_a_oe(port_a_oe), .irq_out(irq_out));

    // Clock of 40 ns period.
    initial
    begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    // Cuts a hang short well beyond the expected run length.
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_total++;
            end_of_test();
        end
    end

    // Prints the verdict and stops the run.
    task automatic end_of_test();
        if (err_total == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Compares one value and counts the outcome.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
            err_total++;
        end
    endtask

    // One APB transfer; waits for pready, then releases after that edge.
    task automatic apb(input logic w, input logic [5:0] ix,
        input logic [7:0] d, output logic [31:0] rd, output logic er);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {ix, 2'b00};
        pwdata <= {24'h0, d};
        penable <= 1'b0;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // Register write.
    task automatic wr(input logic [5:0] ix, input logic [7:0] d);
        logic [31:0] rd;
        logic er;
        apb(1'b1, ix, d, rd, er);
    endtask

    // Register read compared with an expected word.
    task automatic rc(input logic [5:0] ix, input logic [31:0] exp);
        logic [31:0] rd;
        logic er;
        apb(1'b0, ix, 8'h00, rd, er);
        chk(rd, exp);
    endtask

    // One-cycle reset or wake pulse; counts pc_load pulses after it.
    task automatic pulse(input int k, output int loads);
        loads = 0;
        case (k)
            0: por_bor_req <= 1'b1;
            1: warm_rst_req <= 1'b1;
            2: wake_wdt_req <= 1'b1;
            default: wake_irq_req <= 1'b1;
        endcase
        @(posedge pclk);
        {por_bor_req, warm_rst_req, wake_wdt_req, wake_irq_req} <= 4'h0;
        repeat (3)
        begin
            @(negedge pclk);
            if (pc_load === 1'b1)
                loads++;
        end
        @(posedge pclk);
    endtask

    // Power-on value of an index, with port A bits 6 and 7 gated off.
    function automatic logic [7:0] por_of(input int i);
        case (i)
            8, 17: return 8'hFF;
            9: return 8'h40;
            10: return 8'h05;
            12: return 8'h1C;
            30: return 8'h3F;
            default: return 8'h00;
        endcase
    endfunction

    // Main sequence.
    initial
    begin
        int ld;
        logic [31:0] rd;
        logic er;
        logic [20:0] top;
        logic [7:0] sidx;
        logic [7:0] g;
        logic [7:0] ictl [3];
        logic [20:0] pcs [3];
        ictl = '{8'h80, 8'h40, 8'h00};
        pcs = '{21'h012345, 21'h1ABCDE, 21'h0F0F0F};
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {por_bor_req, warm_rst_req, wake_wdt_req, wake_irq_req} = 4'h0;
        {wake_irq_high, osc_frees_pins, wake_flags, pc_in} = '0;
        port_a_in = 8'hFF;
        top = '0;
        sidx = 8'h00;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // Power-on values after reset.
        for (int i = 0; i < 35; i++)
            if (i != 28)
                rc(6'(i), {24'h0, por_of(i)});
        // Unimplemented bits read zero, then warm reset keeps its bits.
        for (int i = 0; i < 10; i++)
        begin
            wr(t_ix[i], 8'hFF);
            rc(t_ix[i], {24'h0, t_im[i]});
            wr(t_ix[i], 8'hA5);
        end
        wr(`RIW_IX_VDET_CTRL, 8'hFF);
        rc(`RIW_IX_VDET_CTRL, 32'hBF);
        wr(`RIW_IX_RST_CAUSE, 8'hFF);
        rc(`RIW_IX_RST_CAUSE, 32'hDF);
        pulse(1, ld);
        for (int i = 0; i < 10; i++)
            rc(t_ix[i], {24'h0, (8'hA5 & t_im[i] & t_kp[i]) |
                (t_po[i] & ~t_kp[i])});
        for (int i = 0; i < 10; i++)
            wr(t_ix[i], 8'hA5);
        // Watchdog wake keeps values, flags the cause, raises interrupt.
        wr(`RIW_IX_EVT_MASK, 8'h04);
        rc(`RIW_IX_EVT_STATUS, 32'h02);
        wake_flags <= 8'h10;
        pulse(2, ld);
        chk(32'(ld), 32'h0);
        @(negedge pclk);
        chk({31'h0, irq_out}, 32'h1);
        rc(`RIW_IX_PERIPH_FLAGS, 32'h10);
        rc(`RIW_IX_EVT_STATUS, 32'h04);
        @(negedge pclk);
        chk({31'h0, irq_out}, 32'h0);
        for (int i = 0; i < 10; i++)
            rc(t_ix[i], {24'h0, (i == 7) ? 8'hFF : 8'hA5 & t_im[i]});
        // Interrupt wakes: high enable, low enable, then neither enable.
        wake_flags <= 8'h21;
        for (int k = 0; k < 3; k++)
        begin
            wr(`RIW_IX_IRQ_CONTROL, ictl[k]);
            pc_in <= pcs[k];
            wake_irq_high <= (k != 1);
            pulse(3, ld);
            if (k < 2)
            begin
                top = pcs[k];
                sidx++;
            end
            chk(32'(ld), {31'h0, k < 2});
            chk({11'h0, pc_vector}, {11'h0, (k == 0) ? `RIW_HIGH_VECTOR :
                `RIW_LOW_VECTOR});
            rc(`RIW_IX_STACK_TOP_UPPER, {27'h0, top[20:16]});
            rc(`RIW_IX_STACK_TOP_HIGH, {24'h0, top[15:8]});
            rc(`RIW_IX_STACK_TOP_LOW, {24'h0, top[7:0]});
            rc(`RIW_IX_STACK_INDEX, {24'h0, sidx});
            rc(`RIW_IX_EVT_STATUS, (k < 2) ? 32'h18 : 32'h08);
        end
        rc(`RIW_IX_PERIPH_FLAGS, 32'h31);
        wake_flags <= 8'h00;
        // Port A bits 6 and 7 follow the oscillator mode.
        for (int m = 0; m < 2; m++)
        begin
            osc_frees_pins <= m[0];
            g = m[0] ? 8'hFF : 8'h3F;
            wr(`RIW_IX_PORT_A_LATCH, 8'hC3);
            wr(`RIW_IX_PORT_A_DIR, 8'h0F);
            rc(`RIW_IX_PORT_A_LATCH, {24'h0, 8'hC3 & g});
            rc(`RIW_IX_PORT_A_DIR, {24'h0, 8'h0F & g});
            rc(`RIW_IX_PORT_A_PINS, {24'h0, g});
            @(negedge pclk);
            chk({24'h0, port_a_out}, {24'h0, 8'hC3 & g});
            chk({24'h0, port_a_oe}, {24'h0, 8'hF0 & g});
        end
        // Unmapped index errors; status is read-only.
        apb(1'b0, 6'd36, 8'h00, rd, er);
        chk(rd, 32'h0);
        chk({31'h0, er}, 32'h1);
        wr(`RIW_IX_EVT_STATUS, 8'hFF);
        rc(`RIW_IX_EVT_STATUS, 32'h0);
        // Power-on class restores the power-on values of the plain registers and the stack index.
        pulse(0, ld);
        for (int i = 0; i < 10; i++)
            rc(t_ix[i], {24'h0, t_po[i]});
        rc(`RIW_IX_STACK_INDEX, 32'h0);
        rc(`RIW_IX_EVT_STATUS, 32'h01);
        end_of_test();
    end
endmodule // tb_top
